// [pkg/spcm_defines.vh]
// offsets, field positions, reset values and counts of the serial port control block
// Functional notes
// - control bit 2 resets receiver, bit 3 resets transmitter; zero does nothing
// - bit 4 enables receiver unless bit 5 set in same write; bit 5 disables
// - bit 6 enables transmitter unless bit 7 set in same write; bit 7 disables
// - bit 8 clears parity, framing, overrun and break-received flags
// - bit 9 starts break after holding and shift registers drain; ignored during break
// - bit 10 ends break after one character length, then 12 idle bit periods
// - bit 11 makes the time-out counter wait for a new character
// - bit 12 in multidrop sends next written character with address bit set
// - bit 13 clears the retry-limit flag, only in smart-card modes
// - bit 18 drives request line low, bit 19 drives it high
// - mode field: 0 normal, 1 RS485, 2 handshake, 4 T=0, 6 T=1, 8 infrared; only 1, 4 and 6 are decoded, 2 and 8 act as 0
// - length field gives 5 to 8 bits; nine-bit select gives 9 bits
// - clocked-mode bit: 0 asynchronous, 1 synchronous
// - check bit: even, odd, forced 0, forced 1, none, multidrop
// - stop bits: 00 one, 01 one and a half async only, 10 two
// - test mode: normal, echo, local loopback, remote loopback
// - bit order select: 0 lsb first, 1 msb first, both directions
// - clock output drives clock pin only when source is not the clock pin
// - in RS485 the request line is the inverse of transmitter idle, guard included
// - local loopback holds tx pin high, ignores rx pin; remote disables tx and rx
`ifndef SPCM_DEFINES_VH
`define SPCM_DEFINES_VH
`define SPCM_A_CR 8'h00
`define SPCM_A_MR 8'h04
`define SPCM_A_IER 8'h08
`define SPCM_A_IDR 8'h0C
`define SPCM_A_IMR 8'h10
`define SPCM_A_CSR 8'h14
`define SPCM_A_RHR 8'h18
`define SPCM_A_THR 8'h1C
`define SPCM_A_BRGR 8'h20
`define SPCM_A_RTOR 8'h24
`define SPCM_A_TTGR 8'h28
`define SPCM_A_FIDI 8'h40
`define SPCM_A_NER 8'h44
`define SPCM_A_IF 8'h4C
`define SPCM_FIDI_RST 11'h174
`define SPCM_MR_MASK 32'h977FFFFF
`define SPCM_MR_MODE 3:0
`define SPCM_MR_CLKS 5:4
`define SPCM_MR_CHAR_LENGTH_FIELD 7:6
`define SPCM_MR_SYNC 8
`define SPCM_MR_PAR 11:9
`define SPCM_MR_STOP 13:12
`define SPCM_MR_CHM 15:14
`define SPCM_MR_BIT_ORDER_SELECT 16
`define SPCM_MR_NINE_BIT_SELECT 17
`define SPCM_MR_CLOCK_OUTPUT_SELECT 18
`define SPCM_MR_OVER 19
`define SPCM_MODE_RS485 4'h1
`define SPCM_MODE_T0 4'h4
`define SPCM_MODE_T1 4'h6
`define SPCM_CLK_MCK 2'h0
`define SPCM_CLK_DIV 2'h1
`define SPCM_CLK_EXT 2'h3
`define SPCM_CHM_ECHO 2'h1
`define SPCM_CHM_LOCAL 2'h2
`define SPCM_CHM_REMOTE 2'h3
`define SPCM_BRK_END_BITS 8'h0C
`endif

// [hdl/spcm_top.v]
// serial port control and mode block with axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
`include "spcm_defines.vh"
module spcm_top #(
	parameter DIV = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [7:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire rxd,
	output reg txd,
	input wire sck_in,
	output reg sck_out,
	output reg sck_oe,
	output reg rts,
	input wire retry_limit_evt,
	input wire negative_ack_evt
);
	localparam [31:0] DIV_W = DIV - 1;
	localparam [7:0] DIV_M1 = DIV_W[7:0];
	localparam [2:0] T_IDLE = 3'h0, T_START = 3'h1, T_DATA = 3'h2, T_PAR = 3'h3;
	localparam [2:0] T_STOP = 3'h4, T_BRK = 3'h5, T_BEND = 3'h6, T_GUARD = 3'h7;
	localparam [2:0] R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h2, R_PAR = 3'h3;
	localparam [2:0] R_STOP = 3'h4, R_BRKW = 3'h5;

	function mapped;
		input [7:0] a;
		begin
			case (a)
			`SPCM_A_CR, `SPCM_A_MR, `SPCM_A_IER, `SPCM_A_IDR, `SPCM_A_IMR, `SPCM_A_CSR,
			`SPCM_A_RHR, `SPCM_A_THR, `SPCM_A_BRGR, `SPCM_A_RTOR, `SPCM_A_TTGR,
			`SPCM_A_FIDI, `SPCM_A_NER, `SPCM_A_IF: mapped = 1'b1;
			default: mapped = 1'b0;
			endcase
		end
	endfunction

	// expected check bit for a character of n bits
	function par_of;
		input [8:0] d;
		input [3:0] n;
		input [2:0] t;
		reg p;
		begin
			p = ^(d & (9'h1FF >> (4'h9 - n)));
			case (t)
			3'h0: par_of = p;
			3'h1: par_of = ~p;
			3'h3: par_of = 1'b1;
			default: par_of = 1'b0;
			endcase
		end
	endfunction

	// ==========================================
	// register bus
	reg aw_f, w_f;
	reg [7:0] wa;
	reg [31:0] wdh;
	reg [3:0] wsh;
	reg [31:0] mr;
	reg [15:0] brgr, rtor;
	reg [7:0] ttgr, ifr, ner;
	reg [10:0] fidi;
	reg [31:0] rmux;
	wire aw_hs = awvalid & awready;
	wire w_hs = wvalid & wready;
	wire ar_hs = arvalid & arready;
	wire do_wr = aw_f & w_f & ~bvalid;
	// response still pending after this edge: no new write taken
	wire b_next = do_wr | (bvalid & ~bready);
	wire [31:0] wd = wdh & {{8{wsh[3]}}, {8{wsh[2]}}, {8{wsh[1]}}, {8{wsh[0]}}};
	wire [31:0] cmd = (do_wr && wa == `SPCM_A_CR) ? wd : 32'h0;
	wire thr_wr = do_wr && wa == `SPCM_A_THR;
	wire rhr_rd = ar_hs && araddr == `SPCM_A_RHR;
	wire ner_rd = ar_hs && araddr == `SPCM_A_NER;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_f <= 1'b0;
			w_f <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rresp <= 2'h0;
			rdata <= 32'h0;
			wa <= 8'h0;
			wdh <= 32'h0;
			wsh <= 4'h0;
		end else begin
			if (aw_hs)
				wa <= awaddr;
			if (w_hs) begin
				wdh <= wdata;
				wsh <= wstrb;
			end
			aw_f <= (aw_f | aw_hs) & ~do_wr;
			w_f <= (w_f | w_hs) & ~do_wr;
			awready <= ~((aw_f | aw_hs) & ~do_wr) & ~b_next;
			wready <= ~((w_f | w_hs) & ~do_wr) & ~b_next;
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp <= mapped(wa) ? 2'h0 : 2'h2;
			end else if (bready)
				bvalid <= 1'b0;
			if (ar_hs) begin
				rvalid <= 1'b1;
				rdata <= rmux;
				rresp <= mapped(araddr) ? 2'h0 : 2'h2;
			end else if (rready)
				rvalid <= 1'b0;
			arready <= ~(ar_hs | (rvalid & ~rready));
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			mr <= 32'h0;
			brgr <= 16'h0;
			rtor <= 16'h0;
			ttgr <= 8'h0;
			fidi <= `SPCM_FIDI_RST;
			ifr <= 8'h0;
		end else if (do_wr) begin
			case (wa)
			`SPCM_A_MR: mr <= wd & `SPCM_MR_MASK;
			`SPCM_A_BRGR: brgr <= wd[15:0];
			`SPCM_A_RTOR: rtor <= wd[15:0];
			`SPCM_A_TTGR: ttgr <= wd[7:0];
			`SPCM_A_FIDI: fidi <= wd[10:0];
			`SPCM_A_IF: ifr <= wd[7:0];
			default: ;
			endcase
		end
	end

	// ==========================================
	// mode decode
	wire [3:0] mode = mr[`SPCM_MR_MODE];
	wire [1:0] clks = mr[`SPCM_MR_CLKS];
	wire [1:0] chm = mr[`SPCM_MR_CHM];
	wire [2:0] ptype = mr[`SPCM_MR_PAR];
	wire sync = mr[`SPCM_MR_SYNC];
	wire bit_order_select = mr[`SPCM_MR_BIT_ORDER_SELECT];
	wire [3:0] nbits = mr[`SPCM_MR_NINE_BIT_SELECT] ? 4'h9 : 4'h5 + {2'h0, mr[`SPCM_MR_CHAR_LENGTH_FIELD]};
	wire has_par = ~ptype[2] | ptype[1];
	wire mdrop = ptype[2] & ptype[1];
	wire [4:0] bl = sync ? 5'h1 : (mr[`SPCM_MR_OVER] ? 5'h8 : 5'h10);
	wire [4:0] half = sync ? 5'h1 : {1'b0, bl[4:1]};
	wire [1:0] nst = mr[`SPCM_MR_STOP];
	wire [5:0] stop_len = (nst == 2'h2) ? {bl, 1'b0} :
		(nst == 2'h1 && !sync) ? {1'b0, bl} + {1'b0, half} : {1'b0, bl};
	wire smart = mode == `SPCM_MODE_T0 || mode == `SPCM_MODE_T1;

	// ==========================================
	// clock source and baud timing
	reg sck_m, sck_s, sck_d, rxd_m, rxd_s;
	reg [7:0] pre;
	reg [15:0] brg;
	reg samp;
	reg [4:0] bt;
	always @(posedge aclk) begin
		sck_m <= sck_in;
		sck_s <= sck_m;
		rxd_m <= rxd;
		rxd_s <= rxd_m;
	end
	wire src_tick = (clks == `SPCM_CLK_MCK) ? 1'b1 :
		(clks == `SPCM_CLK_DIV) ? (pre == 8'h0) :
		(clks == `SPCM_CLK_EXT) ? (sck_s & ~sck_d) : 1'b0;
	wire brg_end = brg >= brgr - 16'h1;
	wire btick = samp && bt + 5'h1 >= bl;
	always @(posedge aclk) begin
		if (!aresetn) begin
			sck_d <= 1'b0;
			pre <= 8'h0;
			brg <= 16'h0;
			samp <= 1'b0;
			bt <= 5'h0;
		end else begin
			sck_d <= sck_s;
			pre <= (pre >= DIV_M1) ? 8'h0 : pre + 8'h1;
			samp <= src_tick && brgr != 16'h0 && brg_end;
			if (src_tick && brgr != 16'h0)
				brg <= brg_end ? 16'h0 : brg + 16'h1;
			if (samp)
				bt <= btick ? 5'h0 : bt + 5'h1;
		end
	end

	// ==========================================
	// transmitter
	reg [2:0] ts;
	reg tx_en, thr_full, thr_addr, send_addr, brk_pend, brk_stop, tx_line;
	reg [8:0] thr, tsh;
	reg tsh_addr;
	reg [5:0] tcnt;
	reg [3:0] tidx;
	reg [7:0] tbits;
	wire tx_go = tx_en && chm != `SPCM_CHM_REMOTE;
	wire transmitter_idle_flag = ts == T_IDLE && !thr_full;
	wire [5:0] tnext = tcnt + 6'h1;
	wire [3:0] tpos = bit_order_select ? nbits - 4'h1 - tidx : tidx;
	wire tpar = mdrop ? tsh_addr : par_of(tsh, nbits, ptype);
	wire tbit_end = samp && tnext >= {1'b0, bl};
	always @(posedge aclk) begin
		if (!aresetn || cmd[3]) begin
			ts <= T_IDLE;
			tx_en <= 1'b0;
			thr_full <= 1'b0;
			thr_addr <= 1'b0;
			send_addr <= 1'b0;
			brk_pend <= 1'b0;
			brk_stop <= 1'b0;
			tx_line <= 1'b1;
			thr <= 9'h0;
			tsh <= 9'h0;
			tsh_addr <= 1'b0;
			tcnt <= 6'h0;
			tidx <= 4'h0;
			tbits <= 8'h0;
		end else begin
			if (cmd[7])
				tx_en <= 1'b0;
			else if (cmd[6])
				tx_en <= 1'b1;
			if (cmd[12] && mdrop)
				send_addr <= 1'b1;
			if (cmd[9] && ts != T_BRK && ts != T_BEND)
				brk_pend <= 1'b1;
			if (cmd[10] && ts == T_BRK)
				brk_stop <= 1'b1;
			if (thr_wr && !thr_full) begin
				thr <= wd[8:0];
				thr_full <= 1'b1;
				thr_addr <= send_addr;
				send_addr <= 1'b0;
			end
			if (samp) begin
				tcnt <= tnext;
				case (ts)
				T_IDLE: begin
					tx_line <= 1'b1;
					tcnt <= 6'h0;
					tbits <= 8'h0;
					if (thr_full && tx_go) begin
						tsh <= thr;
						tsh_addr <= thr_addr;
						tidx <= 4'h0;
						thr_full <= 1'b0;
						tx_line <= 1'b0;
						ts <= T_START;
					end else if (brk_pend && !thr_full) begin
						brk_pend <= 1'b0;
						tx_line <= 1'b0;
						ts <= T_BRK;
					end
				end
				T_START: if (tbit_end) begin
					tcnt <= 6'h0;
					tidx <= 4'h0;
					tx_line <= tsh[tpos];
					ts <= T_DATA;
				end
				T_DATA: if (tbit_end) begin
					tcnt <= 6'h0;
					tidx <= tidx + 4'h1;
					tx_line <= bit_order_select ? tsh[tpos - 4'h1] : tsh[tpos + 4'h1];
					if (tidx + 4'h1 >= nbits) begin
						tx_line <= has_par ? tpar : 1'b1;
						ts <= has_par ? T_PAR : T_STOP;
					end
				end
				T_PAR: if (tbit_end) begin
					tcnt <= 6'h0;
					tx_line <= 1'b1;
					ts <= T_STOP;
				end
				T_STOP: if (tnext >= stop_len) begin
					tcnt <= 6'h0;
					ts <= (ttgr != 8'h0) ? T_GUARD : T_IDLE;
				end
				T_BRK: if (tbit_end) begin
					tcnt <= 6'h0;
					if (tbits < {4'h0, nbits} + 8'h2)
						tbits <= tbits + 8'h1;
					else if (brk_stop) begin
						brk_stop <= 1'b0;
						tbits <= 8'h0;
						tx_line <= 1'b1;
						ts <= T_BEND;
					end
				end
				T_BEND, T_GUARD: if (tbit_end) begin
					tcnt <= 6'h0;
					tbits <= tbits + 8'h1;
					if (tbits + 8'h1 >= (ts == T_BEND ? `SPCM_BRK_END_BITS : ttgr))
						ts <= T_IDLE;
				end
				default: ts <= T_IDLE;
				endcase
			end
		end
	end

	// ==========================================
	// receiver and status flags
	reg [2:0] rs;
	reg rx_en, rxrdy, break_received_flag, parity_error_flag, frame, overrun_error_flag, rpb, rzero;
	reg [8:0] rsh, rhr;
	reg [4:0] rcnt;
	reg [3:0] ridx;
	reg to_wait, to_run, timeout, iter, negative_ack_flag;
	reg [15:0] to_cnt;
	wire rx_go = rx_en && chm != `SPCM_CHM_REMOTE;
	wire rx_in = (chm == `SPCM_CHM_LOCAL) ? tx_line : rxd_s;
	wire [4:0] rnext = rcnt + 5'h1;
	wire [3:0] rpos = bit_order_select ? nbits - 4'h1 - ridx : ridx;
	wire rdone = samp && rs == R_STOP && rnext >= bl;
	wire rperr = has_par && !mdrop && rpb != par_of(rsh, nbits, ptype);
	always @(posedge aclk) begin
		if (!aresetn || cmd[2]) begin
			rs <= R_IDLE;
			rx_en <= 1'b0;
			rxrdy <= 1'b0;
			rsh <= 9'h0;
			rcnt <= 5'h0;
			ridx <= 4'h0;
			rpb <= 1'b0;
			rzero <= 1'b0;
		end else begin
			if (cmd[5])
				rx_en <= 1'b0;
			else if (cmd[4])
				rx_en <= 1'b1;
			if (rhr_rd)
				rxrdy <= 1'b0;
			if (samp) begin
				rcnt <= rnext;
				case (rs)
				R_IDLE: begin
					rcnt <= 5'h0;
					if (rx_go && !rx_in)
						rs <= R_START;
				end
				R_START: if (rnext >= half) begin
					rcnt <= 5'h0;
					ridx <= 4'h0;
					rzero <= 1'b1;
					rsh <= 9'h0;
					rs <= rx_in ? R_IDLE : R_DATA;
				end
				R_DATA: if (rnext >= bl) begin
					rcnt <= 5'h0;
					rsh[rpos] <= rx_in;
					rzero <= rzero & ~rx_in;
					ridx <= ridx + 4'h1;
					if (ridx + 4'h1 >= nbits)
						rs <= has_par ? R_PAR : R_STOP;
				end
				R_PAR: if (rnext >= bl) begin
					rcnt <= 5'h0;
					rpb <= rx_in;
					rzero <= rzero & ~rx_in;
					rs <= R_STOP;
				end
				R_STOP: if (rnext >= bl) begin
					rcnt <= 5'h0;
					rs <= (rzero && !rx_in) ? R_BRKW : R_IDLE;
					if (!(rzero && !rx_in))
						rxrdy <= 1'b1;
				end
				R_BRKW: if (rx_in)
					rs <= R_IDLE;
				default: rs <= R_IDLE;
				endcase
			end
		end
	end

	// flags: a clear command and a set event in one cycle leave the flag set
	always @(posedge aclk) begin
		if (!aresetn) begin
			break_received_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			frame <= 1'b0;
			overrun_error_flag <= 1'b0;
			rhr <= 9'h0;
			ner <= 8'h0;
			iter <= 1'b0;
			negative_ack_flag <= 1'b0;
		end else begin
			if (cmd[8]) begin
				break_received_flag <= 1'b0;
				parity_error_flag <= 1'b0;
				frame <= 1'b0;
				overrun_error_flag <= 1'b0;
			end
			if (cmd[13] && smart)
				iter <= 1'b0;
			if (cmd[14])
				negative_ack_flag <= 1'b0;
			if (retry_limit_evt)
				iter <= 1'b1;
			if (negative_ack_evt)
				negative_ack_flag <= 1'b1;
			if (ner_rd)
				ner <= 8'h0;
			if (rdone) begin
				if (rzero && !rx_in)
					break_received_flag <= 1'b1;
				else begin
					rhr <= rsh;
					if (!rx_in)
						frame <= 1'b1;
					if (rxrdy && !rhr_rd)
						overrun_error_flag <= 1'b1;
					if (rperr) begin
						parity_error_flag <= 1'b1;
						ner <= ner + 8'h1;
					end
				end
			end
		end
	end

	// receiver time-out, counted in bit periods while the line is quiet
	always @(posedge aclk) begin
		if (!aresetn) begin
			to_wait <= 1'b0;
			to_run <= 1'b0;
			timeout <= 1'b0;
			to_cnt <= 16'h0;
		end else begin
			if (cmd[11]) begin
				to_wait <= 1'b1;
				to_run <= 1'b0;
				timeout <= 1'b0;
			end else if (cmd[15] && rtor != 16'h0) begin
				to_run <= 1'b1;
				to_cnt <= rtor;
				timeout <= 1'b0;
			end else if (rdone && rtor != 16'h0) begin
				to_wait <= 1'b0;
				to_run <= 1'b1;
				to_cnt <= rtor;
			end else if (to_run && btick && rs == R_IDLE) begin
				to_cnt <= to_cnt - 16'h1;
				if (to_cnt <= 16'h1) begin
					to_run <= 1'b0;
					timeout <= 1'b1;
				end
			end
		end
	end

	// ==========================================
	// read mux and pins
	wire [31:0] csr = {18'h0, negative_ack_flag, 2'h0, iter, transmitter_idle_flag, timeout, parity_error_flag, frame, overrun_error_flag,
		2'h0, break_received_flag, ~thr_full, rxrdy};
	always @* begin
		case (araddr)
		`SPCM_A_MR: rmux = mr;
		`SPCM_A_CSR: rmux = csr;
		`SPCM_A_RHR: rmux = {23'h0, rhr};
		`SPCM_A_BRGR: rmux = {16'h0, brgr};
		`SPCM_A_RTOR: rmux = {16'h0, rtor};
		`SPCM_A_TTGR: rmux = {24'h0, ttgr};
		`SPCM_A_FIDI: rmux = {21'h0, fidi};
		`SPCM_A_NER: rmux = {24'h0, ner};
		`SPCM_A_IF: rmux = {24'h0, ifr};
		default: rmux = 32'h0;
		endcase
	end

	reg rts_lvl;
	always @(posedge aclk) begin
		if (!aresetn) begin
			txd <= 1'b1;
			sck_out <= 1'b0;
			sck_oe <= 1'b0;
			rts <= 1'b1;
			rts_lvl <= 1'b1;
		end else begin
			if (cmd[18])
				rts_lvl <= 1'b0;
			else if (cmd[19])
				rts_lvl <= 1'b1;
			rts <= (mode == `SPCM_MODE_RS485) ? ~transmitter_idle_flag : rts_lvl;
			case (chm)
			`SPCM_CHM_ECHO, `SPCM_CHM_REMOTE: txd <= rxd_s;
			`SPCM_CHM_LOCAL: txd <= 1'b1;
			default: txd <= tx_line;
			endcase
			sck_oe <= mr[`SPCM_MR_CLOCK_OUTPUT_SELECT] && clks != `SPCM_CLK_EXT;
			sck_out <= sync ? (brg < {1'b0, brgr[15:1]}) : (bt < half);
		end
	end
endmodule
`default_nettype wire

// [dv/spcm_asserts.sv]
// port checker for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module spcm_asserts #(
	parameter DIV = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic txd,
	input wire logic sck_oe,
	input wire logic rts
);
// ==========
// shadow of the last write and of the mode word
logic [7:0] wa;
logic [31:0] wd;
logic [31:0] mr;
logic bad;
assign bad = (wa > 8'h28 && wa < 8'h40) || wa == 8'h48 || wa > 8'h4C;
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		wa <= 8'h00;
		wd <= 32'h0;
		mr <= 32'h0;
	end else begin
		if (awvalid && awready) wa <= awaddr;
		if (wvalid && wready) wd <= wdata;
		if ($rose(bvalid) && wa == 8'h04) mr <= wd;
	end
end
// ==========
// properties
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
write_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
	else $error("write response not two cycles after handshake");
read_resp_a: assert property (arvalid && arready |=> rvalid)
	else $error("read data not one cycle after handshake");
wr_block_a: assert property (bvalid |-> !awready && !wready)
	else $error("write accepted while response pending");
rd_block_a: assert property (rvalid |-> !arready)
	else $error("read accepted while data pending");
resp_done_a: assert property (bvalid && bready |=> !bvalid)
	else $error("write response not released");
data_done_a: assert property (rvalid && rready |=> !rvalid)
	else $error("read data not released");
resp_code_a: assert property ($rose(bvalid) |-> bresp == (bad ? 2'h2 : 2'h0))
	else $error("wrong write response code");
rts_low_a: assert property ($rose(bvalid) && wa == 8'h00 && wd[18] && !wd[19] && mr[3:0] != 4'h1 |=> !rts)
	else $error("request line not driven low");
rts_high_a: assert property ($rose(bvalid) && wa == 8'h00 && wd[19] && !wd[18] && mr[3:0] != 4'h1 |=> rts)
	else $error("request line not driven high");
sck_drive_a: assert property (!mr[18] || mr[5:4] == 2'h3 |-> !sck_oe)
	else $error("clock pin driven when it must not be");
loop_idle_a: assert property (mr[15:14] == 2'h2 |-> txd)
	else $error("transmit pin not idle in local loopback");
endmodule
bind spcm_top spcm_asserts #(.DIV(DIV)) i_spcm_asserts (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
	.wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .txd, .sck_oe, .rts);
`default_nettype wire

// [dv/spcm_peer.sv]
// remote serial peer: sends frames on rxd, captures frames from txd
`timescale 1ns/10ps
`default_nettype none
module spcm_peer (
	input wire logic txd,
	input wire logic sck_run,
	output logic rxd,
	output logic sck
);
int bit_ns = 320;
int nb = 8;
logic [8:0] got_q [$];
initial begin
	rxd = 1'b1;
	sck = 1'b0;
end
// ==========
// link clock stands still outside frames
always #80 sck = sck_run ? ~sck : 1'b0;
// offset keeps line changes away from the sampling edge
task automatic send(input logic [8:0] x);
	#3;
	rxd = 1'b0;
	#(bit_ns);
	for (int i = 0; i < nb; i++) begin
		rxd = x[i];
		#(bit_ns);
	end
	rxd = 1'b1;
	#(2 * bit_ns);
endtask
always begin : cap
	logic [8:0] x;
	@(negedge txd);
	x = 9'h0;
	#(bit_ns / 2);
	for (int i = 0; i < nb; i++) begin
		#(bit_ns);
		x[i] = txd;
	end
	#(bit_ns);
	got_q.push_back(x);
end
endmodule
`default_nettype wire

// [dv/spcm_top_tb.sv]
// self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module spcm_top_tb;
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
logic sck_run = 1'b0, retry_limit_evt = 1'b0, negative_ack_evt = 1'b0;
logic [7:0] awaddr = 8'h00, araddr = 8'h00;
logic [3:0] wstrb = 4'hF;
logic [31:0] wdata = 32'h0, d, mr, mr0;
logic [1:0] r;
logic [8:0] v;
logic [7:0] ra [9] = '{8'h04, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28, 8'h4C, 8'h40, 8'h00};
wire awready, wready, bvalid, arready, rvalid, rxd, txd, sck_in, sck_out, sck_oe, rts;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
int n_fail = 0, n_tests = 0, cyc = 0, k, nb;
bit msb;
always #10 aclk = ~aclk;
spcm_top #(.DIV(8)) i_spcm_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
	.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxd, .txd,
	.sck_in, .sck_out, .sck_oe, .rts, .retry_limit_evt, .negative_ack_evt);
spcm_peer i_spcm_peer (.txd, .sck_run, .rxd, .sck(sck_in));
// ==========
// checking and bus tasks
task automatic results;
	if (n_fail == 0 && n_tests > 0) begin
		$display("*** PASS ***");
	end else begin
		$display("*** FAIL ***");
	end
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	n_tests++;
	if (got !== exp) begin
		n_fail++;
		$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
	end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] x);
	logic pa;
	logic pw;
	pa = 1'b1;
	pw = 1'b1;
	@(posedge aclk);
	awaddr <= a;
	wdata <= x;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	while (pa || pw) begin
		@(posedge aclk);
		if (pa && awready === 1'b1) begin
			awvalid <= 1'b0;
			pa = 1'b0;
		end
		if (pw && wready === 1'b1) begin
			wvalid <= 1'b0;
			pw = 1'b0;
		end
	end
	do @(posedge aclk); while (bvalid !== 1'b1);
	r = bresp;
	bready <= 1'b0;
endtask
task automatic rd(input logic [7:0] a);
	@(posedge aclk);
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	do @(posedge aclk); while (arready !== 1'b1);
	arvalid <= 1'b0;
	do @(posedge aclk); while (rvalid !== 1'b1);
	d = rdata;
	r = rresp;
	rready <= 1'b0;
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] e);
	rd(a);
	chk(d, e);
	chk(r, 2'h0);
endtask
task automatic rx_wait;
	do rd(8'h14); while (d[0] !== 1'b1);
endtask
task automatic tx_wait;
	while (i_spcm_peer.got_q.size() == 0) @(posedge aclk);
endtask
// wire order of a character: reversed within its length when msb first
function automatic logic [8:0] ord(input logic [8:0] x, input int n, input bit m);
	ord = 9'h0;
	for (int j = 0; j < n; j++) ord[j] = m ? x[n - 1 - j] : x[j];
endfunction
always @(posedge aclk) begin
	cyc <= cyc + 1;
	if (cyc == 40000) begin
		n_fail++;
		results();
	end
end
// ==========
// main sequence
initial begin
	void'($urandom(78));
	mr0 = 32'h000808C0;
	repeat (6) @(posedge aclk);
	aresetn <= 1'b1;
	for (k = 0; k < 9; k++) rdc(ra[k], ra[k] == 8'h40 ? 32'h174 : 32'h0);
	rd(8'h30);
	chk(r, 2'h2);
	chk(d, 32'h0);
	wr(8'h48, 32'hFFFF);
	chk(r, 2'h2);
	wr(8'h20, 32'h2);
	rdc(8'h20, 32'h2);
	wr(8'h00, 32'h50);
	for (k = 0; k < 10; k++) begin
		nb = k % 5 + 5;
		msb = k >= 5;
		mr = 32'h00080800 | {msb, 16'h0} | (nb == 9 ? 32'h20000 : (nb - 5) << 6);
		wr(8'h04, mr);
		rdc(8'h04, mr);
		i_spcm_peer.nb = nb;
		v = $urandom;
		wr(8'h1C, {23'h0, v});
		tx_wait();
		chk(i_spcm_peer.got_q.pop_front(), ord(v, nb, msb));
		i_spcm_peer.send(v);
		rx_wait();
		rdc(8'h18, ord(v, nb, msb));
	end
	i_spcm_peer.nb = 9;
	for (k = 0; k < 2; k++) begin
		wr(8'h04, 32'h000800C0 | (k << 9));
		v = $urandom;
		wr(8'h1C, {23'h0, v});
		tx_wait();
		chk(i_spcm_peer.got_q.pop_front(), {(^v[7:0]) ^ k[0], v[7:0]});
	end
	wr(8'h04, mr0);
	i_spcm_peer.nb = 8;
	i_spcm_peer.send(v);
	i_spcm_peer.send(v);
	rd(8'h14);
	chk(d[5], 1'b1);
	wr(8'h00, 32'h100);
	rd(8'h14);
	chk({d[7:5], d[2]}, 4'h0);
	rd(8'h18);
	wr(8'h00, 32'h30);
	i_spcm_peer.send(v);
	rd(8'h14);
	chk(d[0], 1'b0);
	wr(8'h00, 32'h10);
	i_spcm_peer.send(v);
	rdc(8'h18, {24'h0, v[7:0]});
	wr(8'h00, 32'hC0);
	wr(8'h1C, {23'h0, v});
	repeat (400) @(posedge aclk);
	chk(i_spcm_peer.got_q.size(), 0);
	wr(8'h00, 32'h40);
	repeat (400) @(posedge aclk);
	i_spcm_peer.got_q.delete();
	wr(8'h00, 32'h40000);
	@(posedge aclk);
	chk(rts, 1'b0);
	wr(8'h00, 32'h80000);
	@(posedge aclk);
	chk(rts, 1'b1);
	wr(8'h04, mr0 | 32'h1);
	wr(8'h00, 32'h40000);
	wr(8'h1C, {23'h0, v});
	repeat (20) @(posedge aclk);
	chk(rts, 1'b1);
	tx_wait();
	repeat (48) @(posedge aclk);
	chk(rts, 1'b0);
	chk(i_spcm_peer.got_q.pop_front(), v[7:0]);
	@(posedge aclk);
	retry_limit_evt <= 1'b1;
	negative_ack_evt <= 1'b1;
	@(posedge aclk);
	retry_limit_evt <= 1'b0;
	negative_ack_evt <= 1'b0;
	rd(8'h14);
	chk({d[13], d[10]}, 2'b11);
	wr(8'h00, 32'h6000);
	rd(8'h14);
	chk({d[13], d[10]}, 2'b01);
	wr(8'h04, mr0 | 32'h4);
	wr(8'h00, 32'h2000);
	rd(8'h14);
	chk(d[10], 1'b0);
	wr(8'h04, mr0 | 32'h8000);
	wr(8'h1C, {23'h0, v});
	rx_wait();
	rdc(8'h18, {24'h0, v[7:0]});
	chk(i_spcm_peer.got_q.size(), 0);
	wr(8'h04, mr0);
	wr(8'h00, 32'h200);
	repeat (200) @(posedge aclk);
	chk(txd, 1'b0);
	wr(8'h00, 32'h400);
	while (txd !== 1'b1) @(posedge aclk);
	repeat (170) @(posedge aclk);
	chk(txd, 1'b1);
	i_spcm_peer.got_q.delete();
	wr(8'h04, mr0 | 32'h40000);
	@(posedge aclk);
	chk(sck_oe, 1'b1);
	// bit-phase clock out: half of each 16-cycle bit high
	k = 0;
	repeat (64) begin
		@(posedge aclk);
		k += sck_out;
	end
	chk(k, 32);
	wr(8'h04, mr0 | 32'h40030);
	@(posedge aclk);
	chk(sck_oe, 1'b0);
	wr(8'h20, 32'h1);
	i_spcm_peer.bit_ns = 1280;
	sck_run <= 1'b1;
	v = $urandom;
	wr(8'h1C, {23'h0, v});
	tx_wait();
	chk(i_spcm_peer.got_q.pop_front(), v[7:0]);
	sck_run <= 1'b0;
	results();
end
endmodule
`default_nettype wire
